// >>> hw/trap_pkg.sv
// Purpose: Shared constants for the trapezoidal energy filter
// Assumes: One sample clock, synchronous active-high reset
// Notes: Sample period constants derive the cycle count per sample
package trap_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SAMPLE_PERIOD_NS = 20;
  localparam int unsigned CYC_PER_SAMPLE = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LG_LIMIT = 128;
  localparam int unsigned MAX_DEPTH = 2 * LG_LIMIT;
  localparam int unsigned PTR_W = 8;
  localparam int unsigned DEF_LEN = 20;
  localparam int unsigned DEF_GAP = 4;
  localparam int unsigned DEF_DEC_LOG2 = 0;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam logic [PTR_W-1:0] PTR_RST = 8'h00;
endpackage : trap_pkg

// >>> hw/trapezoidal_energy_filter.sv
// Purpose: Running-sum trapezoidal energy filter on a sample stream
// Assumes: Samples arrive with valid from logic on the same clock
// Notes: Output is unnormalized; host divides by the filter length
// Function
// - Output is sum of newest L samples minus L older samples, gap G
// - All window weights are one; new output for every 2^DEC_LOG2 new samples
// - Recursive update: add x(k), x(k-2L-G); subtract x(k-L), x(k-L-G)
// - Output is not normalized; it equals L times the step estimate
// - Length plus gap must stay below 128
// - Accepts one sample every 20 ns at 100 MHz
// - Optional pre-sum of D consecutive samples, D a power of two
`timescale 1ns/100ps

module trap_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input wire logic i_sys_clk, // Clock
  input wire logic i_rst, // Sync reset
  input wire logic i_valid, // Write valid
  output logic o_ready, // Not full
  input wire logic [WIDTH-1:0] i_data, // Write data
  output logic o_valid, // Not empty
  input wire logic i_ready, // Read ready
  output logic [WIDTH-1:0] o_data // Read data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two >= 2");
  end
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } fifo_st_t;
  fifo_st_t s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic wr, rd;
  // Registered room flag so the top-level ready comes from a flop
  assign o_ready = s_q.rdy;
  assign o_valid = (s_q.cnt != '0);
  assign o_data = mem_q[s_q.rp];
  assign wr = i_valid && o_ready;
  assign rd = o_valid && i_ready;
  always_comb begin
    s_d = s_q;
    if (wr) s_d.wp = s_q.wp + 1'b1;
    if (rd) s_d.rp = s_q.rp + 1'b1;
    if (wr && !rd) s_d.cnt = s_q.cnt + 1'b1;
    else if (rd && !wr) s_d.cnt = s_q.cnt - 1'b1;
    s_d.rdy = (s_d.cnt != (AW+1)'(DEPTH));
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
    if (wr) mem_q[s_q.wp] <= i_data;
  end
endmodule : trap_fifo

module trapezoidal_energy_filter
  import trap_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 16,
  parameter int unsigned LEN = trap_pkg::DEF_LEN,
  parameter int unsigned GAP = trap_pkg::DEF_GAP,
  parameter int unsigned DEC_LOG2 = trap_pkg::DEF_DEC_LOG2,
  parameter int unsigned FIFO_D = trap_pkg::FIFO_DEPTH
) (
  input wire logic i_sys_clk, // 100 MHz clock
  input wire logic i_rst, // Sync reset, active high
  input wire logic i_smp_valid, // Sample valid
  output logic o_smp_ready, // Input FIFO not full
  input wire logic signed [SAMPLE_W-1:0] i_smp, // Signed ADC sample
  output logic o_out_valid, // One-cycle output strobe
  output logic signed [SAMPLE_W+DEC_LOG2+8:0] o_energy // L times step height
);
  import trap_pkg::*;
  localparam int unsigned DW = SAMPLE_W + DEC_LOG2; // Pre-summed width
  localparam int unsigned OW = DW + 9; // Holds +-L*2^DW with L<128
  localparam int unsigned D1 = LEN;
  localparam int unsigned D2 = LEN + GAP;
  localparam int unsigned D3 = 2 * LEN + GAP;
  initial begin
    if (LEN + GAP >= LG_LIMIT) $error("LEN+GAP must be below 128");
    if (LEN < 1) $error("LEN must be at least one");
    if (DEC_LOG2 > 6) $error("DEC_LOG2 too large");
  end

  logic f_valid, f_ready;
  logic signed [SAMPLE_W-1:0] f_data;
  // Buffers the pin-side stream; drained once per sample period
  trap_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_D)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_valid(i_smp_valid),
    .o_ready(o_smp_ready),
    .i_data(i_smp),
    .o_valid(f_valid),
    .i_ready(f_ready),
    .o_data(f_data)
  );

  typedef struct packed {
    logic [1:0] pace;
    logic [6:0] dcnt;
    logic signed [DW-1:0] dsum;
    logic [PTR_W-1:0] wp;
    logic signed [OW-1:0] acc;
    logic out_valid;
    logic [PTR_W-1:0] clr;
    logic clr_busy;
  } st_t;
  st_t s_q, s_d;
  logic signed [DW-1:0] hist_q [MAX_DEPTH];
  logic signed [DW-1:0] d_l, d_lg, d_2lg;
  logic take, dec_done, push;
  logic signed [DW-1:0] new_sum;

  // Ring buffer holds MAX_DEPTH (256) samples; taps give the three delays L, L+G, 2L+G
  assign d_l = hist_q[PTR_W'(s_q.wp - PTR_W'(D1))];
  assign d_lg = hist_q[PTR_W'(s_q.wp - PTR_W'(D2))];
  assign d_2lg = hist_q[PTR_W'(s_q.wp - PTR_W'(D3))];
  assign f_ready = (s_q.pace == 2'(CYC_PER_SAMPLE - 1));
  assign take = f_ready && f_valid;
  assign new_sum = s_q.dsum + DW'(f_data);
  assign dec_done = (s_q.dcnt == 7'((1 << DEC_LOG2) - 1));
  assign push = take && dec_done;

  always_comb begin
    s_d = s_q;
    s_d.out_valid = 1'b0;
    s_d.pace = f_ready ? 2'h0 : s_q.pace + 2'h1;
    // Zero history over the 256 cycles after reset; the first 2L+G outputs ramp from a clean baseline only if no sample is taken before the sweep ends
    if (s_q.clr_busy) begin
      s_d.clr = s_q.clr + 8'h01;
      if (s_q.clr == 8'hff) s_d.clr_busy = 1'b0;
    end
    if (take) begin
      if (dec_done) begin
        s_d.dcnt = 7'h00;
        s_d.dsum = '0;
        s_d.wp = s_q.wp + 8'h01;
        // Unit weights, recursive difference of the two windows
        s_d.acc = s_q.acc + OW'(new_sum) - OW'(d_l) - OW'(d_lg) + OW'(d_2lg);
        s_d.out_valid = 1'b1;
      end else begin
        s_d.dcnt = s_q.dcnt + 7'h01;
        s_d.dsum = new_sum;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.wp <= PTR_RST;
      s_q.clr_busy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
    // One writer for the history; a live sample wins over the sweep
    if (s_q.clr_busy) hist_q[s_q.clr] <= '0;
    if (push) hist_q[s_q.wp] <= new_sum;
  end

  assign o_out_valid = s_q.out_valid;
  assign o_energy = s_q.acc; // Unnormalized
endmodule : trapezoidal_energy_filter

// >>> testbench/trap_src_model.sv
// Purpose: ADC sample source. Assumes: offer held until taken. Notes: stall 4 stops offers
`timescale 1ns/100ps
module trap_src_model (
  input wire logic i_sys_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic [2:0] i_stall, // Stall level
  input wire logic i_ready, // Room
  output logic o_valid, // Offer
  output logic [15:0] o_data // Sample
);
  int seed = 23;
  int r;
  initial {o_valid, o_data} = 17'h0;
  always @(posedge i_sys_clk) begin
    r = $random(seed);
    if (!o_valid || i_ready || i_rst) o_data <= r[4] ? {r[5], {15{!r[5]}}} : r[31:16];
    o_valid <= !i_rst && (o_valid && !i_ready || 3'(r[1:0]) >= i_stall);
  end
endmodule : trap_src_model

// >>> testbench/trap_filter_sva.sv
// Purpose: port checks. Assumes: bound to the filter top. Notes: pend_q counts open samples
`timescale 1ns/100ps
module trap_filter_sva #(
  parameter int unsigned SAMPLE_W = 16,
  parameter int unsigned LEN = 20,
  parameter int unsigned DEC_LOG2 = 0,
  parameter int unsigned FIFO_D = 4
) (
  input wire logic i_sys_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_smp_valid, // Offer
  input wire logic o_smp_ready, // Room
  input wire logic o_out_valid, // Strobe
  input wire logic signed [SAMPLE_W+DEC_LOG2+8:0] o_energy // Result
);
  localparam int LIM = LEN << (SAMPLE_W + DEC_LOG2);
  logic [3:0] pend_q;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_take; i_smp_valid && o_smp_ready; endsequence
  always_ff @(posedge i_sys_clk)
    pend_q <= i_rst ? 4'h0 : pend_q + 4'(i_smp_valid && o_smp_ready) - 4'(o_out_valid);
  AST_RST: assert property (disable iff (1'b0) i_rst |=>
    !o_out_valid && o_energy == 0 && o_smp_ready) else $error("bad reset state");
  AST_PULSE: assert property (o_out_valid |=> !o_out_valid)
    else $error("strobe too long");
  AST_HOLD: assert property (!o_out_valid |-> $stable(o_energy))
    else $error("energy moved");
  AST_ANSWER: assert property (s_take |-> ##[1:12] o_out_valid)
    else $error("no answer");
  AST_NOGHOST: assert property (o_out_valid |-> pend_q != 4'h0)
    else $error("strobe without sample");
  AST_READY: assert property (!o_smp_ready |-> pend_q >= 4'(FIFO_D))
    else $error("refused with room");
  AST_FULL: assert property (!o_smp_ready |-> ##[1:3] o_out_valid)
    else $error("full buffer stuck");
  AST_RANGE: assert property (o_out_valid |-> o_energy <= LIM && o_energy >= -LIM)
    else $error("energy out of range");
endmodule : trap_filter_sva
bind trapezoidal_energy_filter trap_filter_sva #(.SAMPLE_W(SAMPLE_W), .LEN(LEN),
  .DEC_LOG2(DEC_LOG2), .FIFO_D(FIFO_D)) u_sva (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready), .o_out_valid(o_out_valid),
  .o_energy(o_energy));

// >>> testbench/tb_trapezoidal_energy_filter.sv
// Purpose: filter bench. Assumes: zero history after reset. Notes: window sum model
`timescale 1ns/100ps
module tb_trapezoidal_energy_filter;
  import trap_pkg::*;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_smp_valid, o_smp_ready, o_out_valid;
  logic [2:0] stall = 3'h4;
  logic signed [15:0] i_smp;
  logic signed [24:0] o_energy;
  int miscompares = 0, checks = 0, n = 0, e, h[$];
  trapezoidal_energy_filter dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready), .i_smp(i_smp),
    .o_out_valid(o_out_valid), .o_energy(o_energy));
  trap_src_model src (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_stall(stall),
    .i_ready(o_smp_ready), .o_valid(i_smp_valid), .o_data(i_smp));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  function automatic int x(int i);
    return (i >= 0 && i < h.size()) ? h[i] : 0;
  endfunction : x
  task automatic check(input logic [24:0] seen, input logic [24:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic restart;
    stall <= 3'h4;
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (260) @(posedge i_sys_clk);
  endtask : restart
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      h.delete();
      n = 0;
    end else begin
      if (i_smp_valid && o_smp_ready) h.push_back(i_smp);
      if (o_out_valid) begin
        e = 0;
        for (int j = 0; j < DEF_LEN; j++) e += x(n - j) - x(n - DEF_LEN - DEF_GAP - j);
        check(o_energy, 25'(e));
        n++;
      end
    end
  end
  initial begin
    restart();
    for (int s = 0; s < 4; s++) begin
      stall <= 3'(s);
      repeat (400) @(posedge i_sys_clk);
      if (s == 1) restart();
      stall <= 3'h4;
      repeat (4) @(negedge i_sys_clk);
      for (int t = 0; t < 100 && n < h.size(); t++) @(negedge i_sys_clk);
      check(25'(n), 25'(h.size()));
      @(posedge i_sys_clk);
    end
    summarize();
  end
endmodule : tb_trapezoidal_energy_filter
